/* core/cgt_pkg.sv */
// Purpose: Shared constants and types for the gated trigger counter
// Assumes: One 250 MHz clock, synchronous active-low reset
// Notes:   Bus offsets are byte addresses of 32-bit words
// How it works
// (R1) Hardware one-shot waits for a gate edge while armed; disarmed edges ignored.
// (R2) Hardware one-shot ignores the gate until its count cycle ends.
// (R3) Hardware one-shot: first terminal count reloads hold, second reloads load and halts.
// (R4) Level strobe counts after arm, only source edges seen while gate active.
// (R5) Level strobe: terminal count reloads load and disarms; new arm needed.
// (R6) Level strobe: gate rise saves count to hold, next edge loads, then counts.
// (R7) Level modes qualify a source edge only while the gate is active.
// (R8) Edge strobe: gate rise when armed starts counting; terminal count reloads, disarms.
// (R9) Host must arm first, then give the gate edge, for edge strobe.
// (R10) Edge strobe: every gate rise retriggers via hold save and deferred load; the code retriggers only while armed.
// (R11) Sync rate generator counts qualified edges repeatedly, reloading load each time.
// (R12) Sync rate generator: any gate rise saves count and retriggers.
// (R13) Retriggerable one-shot: gate edge starts; terminal count reloads load, stops, stays armed.
// (R14) Retriggerable one-shot: every gate edge saves count and retriggers; the code does so only while armed.
// (R15) Gate-selected mode: gate low reloads load, high reloads hold, for all reloads.
// (R16) Gate-selected mode: gate never starts, stops or qualifies counting.
// (R17) Gate-selected mode: two terminal counts then disarm; new arm needed.
// (R18) Terminal count follows 0001 down, 9999 decimal up, FFFF binary up.
// (R19) Terminal count lasts at most one count-source period.
// (R20) Each counter picks its behaviour from its own counter mode field.
package cgt_pkg;

   localparam logic [4:0]  OFS_MODE   = 5'h00;
   localparam logic [4:0]  OFS_LOAD   = 5'h04;
   localparam logic [4:0]  OFS_HOLD   = 5'h08;
   localparam logic [4:0]  OFS_COUNT  = 5'h0C;
   localparam logic [4:0]  OFS_CMD    = 5'h10;
   localparam logic [4:0]  OFS_STATUS = 5'h14;

   localparam int          CFG_W      = 5;
   localparam int          CMD_W      = 3;
   localparam int          STAT_W     = 6;

   localparam logic [15:0] LOAD_RST   = 16'h0000;
   localparam logic [15:0] HOLD_RST   = 16'h0000;
   localparam logic [15:0] COUNT_RST  = 16'h0000;

   localparam logic [15:0] END_DOWN   = 16'h0001;
   localparam logic [15:0] END_BCD_UP = 16'h9999;
   localparam logic [15:0] END_BIN_UP = 16'hFFFF;

   typedef enum logic [2:0] {
      MODE_HW_ONESHOT     = 3'h0,
      MODE_LVL_STROBE     = 3'h1,
      MODE_EDGE_STROBE    = 3'h2,
      MODE_SYNC_RATE      = 3'h3,
      MODE_RETRIG_ONESHOT = 3'h4,
      MODE_GATE_RELOAD    = 3'h5
   } cgt_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN1 = 3'b010,
      ST_RUN2 = 3'b100
   } cgt_state_t;

   typedef struct packed {
      logic      bcd;
      logic      up;
      cgt_mode_t mode;
   } cgt_cfg_t;

   localparam cgt_cfg_t CFG_RST = '{bcd: 1'b0, up: 1'b0, mode: MODE_HW_ONESHOT};

   typedef struct packed {
      logic load;
      logic disarm;
      logic arm;
   } cgt_cmd_t;

endpackage

/* core/cgt_edge.sv */
// Purpose: Rising edge detector for a synchronous input
// Assumes: Input already synchronous to CLK
// Notes:   Pulse is combinational, one cycle wide
`timescale 1ns/1ps
module cgt_edge (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic d,
   output logic      rise
);
   logic prev_reg;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= d;
      end
   end

   assign rise = d & ~prev_reg;
endmodule

/* core/cgt_step.sv */
// Purpose: Next count value and end-of-count detect, binary or decimal
// Assumes: Decimal values hold valid digits
// Notes:   Purely combinational
`timescale 1ns/1ps
module cgt_step
   import cgt_pkg::*;
#(
   parameter int DIGITS = 4
) (
   input  wire logic [4*DIGITS-1:0] value,
   input  wire logic                up,
   input  wire logic                bcd,
   output logic      [4*DIGITS-1:0] next_value,
   output logic                     at_end
);
   localparam int W = 4 * DIGITS;

   logic [DIGITS:0]   carry;
   logic [W-1:0]      dec_value;

   assign carry[0] = 1'b1;

   genvar i;
   generate
      for (i = 0; i < DIGITS; i++) begin : g_digit
         logic [3:0] d;
         assign d = value[4*i +: 4];
         always_comb begin
            dec_value[4*i +: 4] = d;
            carry[i+1]          = 1'b0;
            if (carry[i]) begin
               if (up) begin
                  dec_value[4*i +: 4] = (d == 4'h9) ? 4'h0 : d + 4'h1;
                  carry[i+1]          = (d == 4'h9);
               end else begin
                  dec_value[4*i +: 4] = (d == 4'h0) ? 4'h9 : d - 4'h1;
                  carry[i+1]          = (d == 4'h0);
               end
            end
         end
      end
   endgenerate

   always_comb begin
      if (bcd) begin
         next_value = dec_value;
      end else if (up) begin
         next_value = value + W'(1);
      end else begin
         next_value = value - W'(1);
      end
   end

   // The value before the virtual zero marks the end
   always_comb begin
      if (!up) begin
         at_end = (value == W'(END_DOWN));       // [R18]
      end else if (bcd) begin
         at_end = (value == W'(END_BCD_UP));     // [R18]
      end else begin
         at_end = (value == W'(END_BIN_UP));     // [R18]
      end
   end
endmodule

/* core/cgt_core.sv */
// Purpose: One gated counter with six trigger modes and an Avalon-MM slave
// Assumes: GATE and SRC are synchronous to CLK, gate active high
// Notes:   Each bus access takes exactly one wait cycle
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module cgt_core (
   input  wire logic                CLK,
   input  wire logic                RST_B,
   input  wire logic [4:0]          AVS_ADDRESS,
   input  wire logic                AVS_READ,
   input  wire logic                AVS_WRITE,
   input  wire logic [3:0]          AVS_BYTEENABLE,
   input  wire logic [31:0]         AVS_WRITEDATA,
   output logic      [31:0]         AVS_READDATA,
   output logic                     AVS_WAITREQUEST,
   input  wire logic                GATE,
   input  wire logic                SRC,
   output logic                     TERMINAL_COUNT,
   output cgt_pkg::cgt_state_t      RUN_STATE
);
   import cgt_pkg::*;

   // Bus side
   logic                 req;
   logic                 ack_reg;
   logic                 wr_take;
   logic                 wr_mode;
   logic                 wr_load;
   logic                 wr_hold;
   logic [31:0]          rdata_reg;
   logic [31:0]          status_word;

   // Registers
   cgt_cfg_t             cfg_reg;
   logic [15:0]          load_reg;
   logic [15:0]          hold_reg;
   logic [15:0]          count_reg;
   logic                 armed_reg;
   cgt_state_t           state_reg;
   logic                 pend_reg;
   logic                 tc_reg;

   // Events
   logic                 src_rise;
   logic                 gate_rise;
   cgt_cmd_t             cmd;
   logic                 cmd_wr;

   // Mode decode
   logic                 level_mode;
   logic                 gated_mode;
   logic                 retrig_mode;

   // Counting control
   logic                 qual;
   logic                 ld_sel_hold;
   logic                 cnt_en;
   logic                 trig;
   logic                 retrig;
   logic                 tc_hit;
   logic                 tc_disarm;
   cgt_state_t           tc_state;
   logic [15:0]          reload_val;

   // Step unit
   logic [15:0]          step_val;
   logic                 at_end;

   // Byte-lane merge for the 16-bit registers
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   // Inputs idle low, so reset leaves no false edge
   cgt_edge u_src_edge (
      .clk   (CLK),
      .rst_b (RST_B),
      .d     (SRC),
      .rise  (src_rise)
   );

   cgt_edge u_gate_edge (
      .clk   (CLK),
      .rst_b (RST_B),
      .d     (GATE),
      .rise  (gate_rise)
   );

   cgt_step #(
      .DIGITS (4)
   ) u_step (
      .value      (count_reg),
      .up         (cfg_reg.up),
      .bcd        (cfg_reg.bcd),
      .next_value (step_val),
      .at_end     (at_end)
   );

   // Avalon slave: first cycle waits and fetches read data, second completes
   assign req             = AVS_READ | AVS_WRITE;
   assign AVS_WAITREQUEST = req & ~ack_reg;
   assign wr_take         = AVS_WRITE & ack_reg;
   assign AVS_READDATA    = rdata_reg;

   // Status bits: armed, phase, terminal count, retrigger pending
   assign status_word = {{(32-STAT_W){1'b0}}, pend_reg, tc_reg, state_reg, armed_reg};

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req & ~ack_reg;
      end
   end

   // Fetch on the waiting cycle so data stand at the answer
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         rdata_reg <= 32'h00000000;
      end else if (AVS_READ && !ack_reg) begin
         case (AVS_ADDRESS)
            OFS_MODE:   rdata_reg <= {{(32-CFG_W){1'b0}}, cfg_reg};
            OFS_LOAD:   rdata_reg <= {16'h0000, load_reg};
            OFS_HOLD:   rdata_reg <= {16'h0000, hold_reg};
            OFS_COUNT:  rdata_reg <= {16'h0000, count_reg};
            OFS_STATUS: rdata_reg <= status_word;
            default:    rdata_reg <= 32'h00000000;
         endcase
      end
   end

   // Commands are write-only strobes; reading the slot gives zero
   assign cmd_wr = wr_take && (AVS_ADDRESS == OFS_CMD) && AVS_BYTEENABLE[0];
   assign cmd    = cmd_wr ? cgt_cmd_t'(AVS_WRITEDATA[CMD_W-1:0]) : cgt_cmd_t'(3'h0);

   // One write strobe per writable register; count is read-only
   assign wr_mode = wr_take && (AVS_ADDRESS == OFS_MODE) && AVS_BYTEENABLE[0];
   assign wr_load = wr_take && (AVS_ADDRESS == OFS_LOAD);
   assign wr_hold = wr_take && (AVS_ADDRESS == OFS_HOLD);

   // Mode field should only change while disarmed; no guard is built in
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         cfg_reg <= CFG_RST;
      end else if (wr_mode) begin
         cfg_reg <= cgt_cfg_t'(AVS_WRITEDATA[CFG_W-1:0]);         // [R20]
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         load_reg <= LOAD_RST;
      end else if (wr_load) begin
         load_reg <= merge16(load_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
   end

   // Mode decode
   always_comb begin
      level_mode  = 1'b0;
      gated_mode  = 1'b0;
      retrig_mode = 1'b0;
      case (cfg_reg.mode)                                         // [R20]
         MODE_HW_ONESHOT: begin
            gated_mode  = 1'b1;
         end
         MODE_LVL_STROBE: begin
            level_mode  = 1'b1;
            retrig_mode = 1'b1;
         end
         MODE_EDGE_STROBE: begin
            gated_mode  = 1'b1;
            retrig_mode = 1'b1;
         end
         MODE_SYNC_RATE: begin
            level_mode  = 1'b1;
            retrig_mode = 1'b1;
         end
         MODE_RETRIG_ONESHOT: begin
            gated_mode  = 1'b1;
            retrig_mode = 1'b1;
         end
         MODE_GATE_RELOAD:    ;                                   // [R16]
         default:             ;
      endcase
   end

   // Level modes only see edges while the gate is active
   assign qual = src_rise & (~level_mode | GATE);                 // [R4] [R7]

   // Gate-selected mode loads from hold while the gate is high
   assign ld_sel_hold = (cfg_reg.mode == MODE_GATE_RELOAD) & GATE;   // [R15]

   // Gate-triggered modes also need the run phase; undefined codes never count
   always_comb begin
      case (cfg_reg.mode)
         MODE_HW_ONESHOT,
         MODE_EDGE_STROBE,
         MODE_RETRIG_ONESHOT: cnt_en = armed_reg && state_reg != ST_IDLE;   // [R1] [R8] [R13]
         MODE_LVL_STROBE,
         MODE_SYNC_RATE,
         MODE_GATE_RELOAD:    cnt_en = armed_reg;                 // [R4] [R11] [R16]
         default:             cnt_en = 1'b0;
      endcase
   end

   // Starting edge: armed and idle only, so later edges cannot restart the cycle
   assign trig = gate_rise & gated_mode & armed_reg & (state_reg == ST_IDLE);  // [R1] [R2]

   // Sync rate generator retriggers even when not armed
   assign retrig = gate_rise & retrig_mode &
                   (armed_reg | (cfg_reg.mode == MODE_SYNC_RATE));  // [R6] [R10] [R12] [R14]

   // A pending reload takes the edge, so no terminal count then
   assign tc_hit = qual & cnt_en & ~pend_reg & at_end;            // [R18]

   // Reload source and phase change at terminal count
   always_comb begin
      reload_val = load_reg;
      tc_disarm  = 1'b0;
      tc_state   = state_reg;
      case (cfg_reg.mode)
         MODE_HW_ONESHOT: begin
            if (state_reg == ST_RUN1) begin
               reload_val = hold_reg;                             // [R3]
               tc_state   = ST_RUN2;
            end else begin
               tc_state   = ST_IDLE;                              // [R3]
            end
         end
         MODE_LVL_STROBE: begin
            tc_disarm = 1'b1;                                     // [R5]
            tc_state  = ST_IDLE;
         end
         MODE_EDGE_STROBE: begin
            tc_disarm = 1'b1;                                     // [R8]
            tc_state  = ST_IDLE;
         end
         MODE_SYNC_RATE:      ;                                   // [R11]
         MODE_RETRIG_ONESHOT: begin
            tc_state = ST_IDLE;                                   // [R13]
         end
         MODE_GATE_RELOAD: begin
            reload_val = GATE ? hold_reg : load_reg;              // [R15]
            if (state_reg == ST_RUN1) begin
               tc_state  = ST_RUN2;
            end else begin
               tc_state  = ST_IDLE;                               // [R17]
               tc_disarm = 1'b1;
            end
         end
         default:             ;
      endcase
   end

   // Load command wins over any source edge in the same cycle
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         count_reg <= COUNT_RST;
      end else if (cmd.load) begin
         if (ld_sel_hold) begin
            count_reg <= hold_reg;                                // [R15]
         end else begin
            count_reg <= load_reg;
         end
      end else if (qual && pend_reg) begin
         count_reg <= load_reg;                                   // [R6] [R10] [R12] [R14]
      end else if (qual && cnt_en) begin
         count_reg <= at_end ? reload_val : step_val;             // [R3] [R11]
      end
   end

   // A gate capture beats a bus write landing in the same cycle
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         hold_reg <= HOLD_RST;
      end else if (retrig) begin
         hold_reg <= count_reg;                                   // [R6] [R10] [R12] [R14]
      end else if (wr_hold) begin
         hold_reg <= merge16(hold_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
   end

   // Pending reload: the next qualified edge loads, the one after counts
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         pend_reg <= 1'b0;
      end else if (retrig) begin
         pend_reg <= 1'b1;                                        // [R10] [R14]
      end else if (cmd.disarm || qual) begin
         pend_reg <= 1'b0;                                        // [R6] [R12]
      end
   end

   // Arm beats a self-disarm in the same cycle so the command is not lost
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         armed_reg <= 1'b0;
      end else if (cmd.arm) begin
         armed_reg <= 1'b1;                                       // [R9]
      end else if (cmd.disarm) begin
         armed_reg <= 1'b0;
      end else if (tc_hit && tc_disarm) begin
         armed_reg <= 1'b0;                                       // [R5] [R8] [R17]
      end
   end

   // Arm in gate-triggered modes still waits for the gate edge
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         state_reg <= ST_IDLE;
      end else if (cmd.arm) begin
         state_reg <= gated_mode ? ST_IDLE : ST_RUN1;             // [R1] [R17]
      end else if (cmd.disarm) begin
         state_reg <= ST_IDLE;
      end else if (tc_hit) begin
         state_reg <= tc_state;                                   // [R3] [R13]
      end else if (trig) begin
         state_reg <= ST_RUN1;                                    // [R1] [R8] [R13]
      end
   end

   // Any next source edge ends the pulse, gated or not
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         tc_reg <= 1'b0;
      end else if (tc_hit) begin
         tc_reg <= 1'b1;                                          // [R18]
      end else if (src_rise) begin
         tc_reg <= 1'b0;                                          // [R19]
      end
   end

   // Both outputs straight from flip-flops
   assign TERMINAL_COUNT = tc_reg;
   assign RUN_STATE      = state_reg;
endmodule

/* verif/cgt_far.sv */
// Purpose: Far side model driving the gate and count source
// Assumes: Called right after a rising edge of CLK
// Notes:   Source stays low between pulses
`timescale 1ns/1ps
module cgt_far (
   input  wire logic CLK,
   output logic      GATE,
   output logic      SRC
);
   initial begin
      GATE = 1'b0;
      SRC  = 1'b0;
   end

   // High one cycle, low one cycle: each is one source edge
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge CLK);
         SRC <= 1'b1;
         @(posedge CLK);
         SRC <= 1'b0;
      end
      @(posedge CLK);
   endtask

   // Two edges so the level change is sampled before return
   task automatic gate(input logic v);
      @(posedge CLK);
      GATE <= v;
      @(posedge CLK);
      @(posedge CLK);
   endtask
endmodule

/* verif/cgt_assertions.sv */
// Purpose: Port level checks for the gated trigger counter
// Assumes: One clock domain, reset disables every check
// Notes:   A source edge is SRC low then high on two samples
`timescale 1ns/1ps
module cgt_assertions
   import cgt_pkg::*;
(
   input wire logic        CLK,
   input wire logic        RST_B,
   input wire logic [4:0]  AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [3:0]  AVS_BYTEENABLE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   input wire logic        GATE,
   input wire logic        SRC,
   input wire logic        TERMINAL_COUNT,
   input wire cgt_state_t  RUN_STATE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   sequence s_src_rise;
      !SRC ##1 SRC;
   endsequence
   sequence s_req_rise;
      !(AVS_READ || AVS_WRITE) ##1 (AVS_READ || AVS_WRITE);
   endsequence

   AST_TC_CLEARS: assert property (TERMINAL_COUNT ##0 s_src_rise |=> !TERMINAL_COUNT)
      else $error("terminal count outlived one source period");
   AST_TC_ON_EDGE: assert property ($rose(TERMINAL_COUNT) |-> $past(SRC) && !$past(SRC, 2))
      else $error("terminal count rose without a source edge");
   AST_TC_DROP: assert property ($fell(TERMINAL_COUNT) |-> $past(SRC) && !$past(SRC, 2))
      else $error("terminal count fell without a source edge");
   AST_SECOND_TC_IDLE: assert property (
      $rose(TERMINAL_COUNT) && $past(RUN_STATE) == ST_RUN2 |-> RUN_STATE == ST_IDLE)
      else $error("second terminal count did not halt");
   AST_STATE_ONEHOT: assert property ($onehot(RUN_STATE))
      else $error("run state not one-hot");
   AST_ONE_WAIT: assert property (s_req_rise |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
      else $error("bus answer not after one wait cycle");
   AST_NO_IDLE_WAIT: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
      else $error("waitrequest without a request");
   AST_RDATA_HOLD: assert property (!AVS_READ |=> $stable(AVS_READDATA))
      else $error("read data changed without a read");
   AST_EMPTY_ZERO: assert property (AVS_READ && !AVS_WAITREQUEST
      && AVS_ADDRESS inside {5'h10, 5'h18, 5'h1C} |-> AVS_READDATA == 32'h0)
      else $error("write-only or empty address read nonzero");
   AST_HIGH_ZERO: assert property (AVS_READ && !AVS_WAITREQUEST
      && AVS_ADDRESS inside {5'h04, 5'h08, 5'h0C} |-> AVS_READDATA[31:16] == 16'h0)
      else $error("upper half of a 16-bit register nonzero");
endmodule

bind cgt_core cgt_assertions u_chk (.CLK, .RST_B, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
   .AVS_BYTEENABLE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .GATE, .SRC,
   .TERMINAL_COUNT, .RUN_STATE);

/* verif/cgt_core_tb.sv */
// Purpose: Self-checking bench for the gated trigger counter
// Assumes: Partner drives GATE and SRC, bench drives the bus
// Notes:   Small load values, or ones a step from the end, keep every terminal count in reach
`timescale 1ns/1ps
module cgt_core_tb;
   import cgt_pkg::*;
   logic        CLK;
   logic        RST_B;
   logic [4:0]  AVS_ADDRESS;
   logic        AVS_READ;
   logic        AVS_WRITE;
   logic [3:0]  AVS_BYTEENABLE;
   logic [31:0] AVS_WRITEDATA;
   logic [31:0] AVS_READDATA;
   logic        AVS_WAITREQUEST;
   logic        GATE;
   logic        SRC;
   logic        TERMINAL_COUNT;
   cgt_state_t  RUN_STATE;
   int          err_count;
   int          num_checks;

   cgt_core dut (.CLK, .RST_B, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_BYTEENABLE,
      .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .GATE, .SRC, .TERMINAL_COUNT,
      .RUN_STATE);
   cgt_far far (.CLK, .GATE, .SRC);

   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end

   task automatic conclude();
      if (err_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held until waitrequest is sampled low
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      AVS_ADDRESS   <= a;
      // Upper lanes carry junk that no register may keep
      AVS_WRITEDATA <= {~d[15:0], d[15:0]};
      AVS_WRITE     <= 1'b1;
      do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
      AVS_WRITE <= 1'b0;
      @(posedge CLK);
   endtask

   task automatic wrb(input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
      AVS_BYTEENABLE <= b;
      wr(a, d);
      AVS_BYTEENABLE <= 4'hF;
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      AVS_ADDRESS <= a;
      AVS_READ    <= 1'b1;
      do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
      chk(AVS_READDATA & m, e);
      AVS_READ <= 1'b0;
      @(posedge CLK);
   endtask

   task automatic tc(input logic e);
      chk({31'h0, TERMINAL_COUNT}, {31'h0, e});
   endtask

   task automatic st(input cgt_state_t e);
      chk({29'h0, RUN_STATE}, {29'h0, e});
   endtask

   task automatic t_reset();
      rd(OFS_MODE, 32'hFFFFFFFF, 32'h0);
      rd(OFS_LOAD, 32'hFFFFFFFF, 32'h0);
      rd(OFS_HOLD, 32'hFFFFFFFF, 32'h0);
      wrb(OFS_LOAD, 32'h1234, 4'h5);
      rd(OFS_LOAD, 32'hFFFFFFFF, 32'h34);
      wrb(OFS_LOAD, 32'h5678, 4'hA);
      rd(OFS_LOAD, 32'hFFFFFFFF, 32'h5634);
      wr(OFS_COUNT, 32'h7);
      rd(OFS_COUNT, 32'hFFFFFFFF, 32'h0);
      rd(OFS_CMD, 32'hFFFFFFFF, 32'h0);
      rd(5'h18, 32'hFFFFFFFF, 32'h0);
      tc(1'b0);
      st(ST_IDLE);
   endtask

   task automatic t_hw();
      wr(OFS_MODE, 32'h0);
      wr(OFS_LOAD, 32'h2);
      wr(OFS_HOLD, 32'h3);
      wr(OFS_CMD, 32'h4);
      far.gate(1'b1);
      far.gate(1'b0);
      far.pulse(1);
      rd(OFS_COUNT, 32'hFFFF, 32'h2);
      wr(OFS_CMD, 32'h1);
      far.gate(1'b1);
      far.pulse(1);
      rd(OFS_COUNT, 32'hFFFF, 32'h1);
      far.pulse(1);
      tc(1'b1);
      st(ST_RUN2);
      rd(OFS_COUNT, 32'hFFFF, 32'h3);
      far.gate(1'b0);
      far.gate(1'b1);
      far.pulse(1);
      tc(1'b0);
      rd(OFS_COUNT, 32'hFFFF, 32'h2);
      far.pulse(2);
      tc(1'b1);
      st(ST_IDLE);
      rd(OFS_COUNT, 32'hFFFF, 32'h2);
      far.pulse(2);
      rd(OFS_COUNT, 32'hFFFF, 32'h2);
   endtask

   task automatic t_level();
      far.gate(1'b0);
      wr(OFS_MODE, 32'h1);
      wr(OFS_LOAD, 32'h3);
      wr(OFS_HOLD, 32'h0);
      wr(OFS_CMD, 32'h5);
      far.pulse(2);
      rd(OFS_COUNT, 32'hFFFF, 32'h3);
      far.gate(1'b1);
      rd(OFS_HOLD, 32'hFFFF, 32'h3);
      far.pulse(2);
      rd(OFS_COUNT, 32'hFFFF, 32'h2);
      far.pulse(2);
      tc(1'b1);
      rd(OFS_COUNT, 32'hFFFF, 32'h3);
      rd(OFS_STATUS, 32'h1, 32'h0);
      far.pulse(1);
      tc(1'b0);
      rd(OFS_COUNT, 32'hFFFF, 32'h3);
   endtask

   task automatic t_edge();
      far.gate(1'b0);
      wr(OFS_MODE, 32'h2);
      wr(OFS_LOAD, 32'h2);
      wr(OFS_HOLD, 32'h5);
      wr(OFS_CMD, 32'h4);
      far.gate(1'b1);
      far.pulse(1);
      rd(OFS_HOLD, 32'hFFFF, 32'h5);
      rd(OFS_COUNT, 32'hFFFF, 32'h2);
      far.gate(1'b0);
      wr(OFS_CMD, 32'h1);
      far.gate(1'b1);
      rd(OFS_HOLD, 32'hFFFF, 32'h2);
      far.gate(1'b0);
      far.pulse(2);
      rd(OFS_COUNT, 32'hFFFF, 32'h1);
      far.pulse(1);
      tc(1'b1);
      rd(OFS_STATUS, 32'h1, 32'h0);
   endtask

   task automatic t_sync();
      wr(OFS_MODE, 32'h3);
      wr(OFS_LOAD, 32'h3);
      wr(OFS_CMD, 32'h5);
      far.pulse(1);
      rd(OFS_COUNT, 32'hFFFF, 32'h3);
      far.gate(1'b1);
      far.pulse(3);
      rd(OFS_COUNT, 32'hFFFF, 32'h1);
      far.pulse(1);
      tc(1'b1);
      rd(OFS_COUNT, 32'hFFFF, 32'h3);
      far.pulse(1);
      far.gate(1'b0);
      far.gate(1'b1);
      rd(OFS_HOLD, 32'hFFFF, 32'h2);
      far.pulse(1);
      rd(OFS_COUNT, 32'hFFFF, 32'h3);
   endtask

   task automatic t_retrig();
      far.gate(1'b0);
      wr(OFS_MODE, 32'h4);
      wr(OFS_LOAD, 32'h2);
      wr(OFS_HOLD, 32'h0);
      wr(OFS_CMD, 32'h5);
      far.pulse(1);
      rd(OFS_COUNT, 32'hFFFF, 32'h2);
      far.gate(1'b1);
      far.gate(1'b0);
      rd(OFS_HOLD, 32'hFFFF, 32'h2);
      far.pulse(3);
      tc(1'b1);
      rd(OFS_STATUS, 32'h1, 32'h1);
      far.pulse(2);
      rd(OFS_COUNT, 32'hFFFF, 32'h2);
      far.gate(1'b1);
      far.pulse(2);
      rd(OFS_COUNT, 32'hFFFF, 32'h1);
   endtask

   task automatic t_gsel();
      wr(OFS_MODE, 32'h5);
      wr(OFS_LOAD, 32'h2);
      wr(OFS_HOLD, 32'h3);
      wr(OFS_CMD, 32'h4);
      rd(OFS_COUNT, 32'hFFFF, 32'h3);
      far.gate(1'b0);
      wr(OFS_CMD, 32'h5);
      rd(OFS_COUNT, 32'hFFFF, 32'h2);
      far.pulse(1);
      rd(OFS_COUNT, 32'hFFFF, 32'h1);
      far.gate(1'b1);
      far.pulse(1);
      st(ST_RUN2);
      rd(OFS_COUNT, 32'hFFFF, 32'h3);
      far.gate(1'b0);
      far.pulse(4);
      st(ST_IDLE);
      rd(OFS_COUNT, 32'hFFFF, 32'h2);
      rd(OFS_STATUS, 32'h1, 32'h0);
   endtask

   // Up counts reach their end one step after the last value
   task automatic t_up(input logic [31:0] m, input logic [31:0] v);
      wr(OFS_CMD, 32'h2);
      wr(OFS_MODE, m);
      wr(OFS_LOAD, v);
      wr(OFS_CMD, 32'h5);
      far.pulse(1);
      tc(1'b0);
      far.pulse(1);
      tc(1'b1);
      rd(OFS_COUNT, 32'hFFFF, v);
   endtask

   initial begin
      err_count      = 0;
      num_checks     = 0;
      RST_B          = 1'b0;
      AVS_ADDRESS    = 5'h00;
      AVS_READ       = 1'b0;
      AVS_WRITE      = 1'b0;
      AVS_BYTEENABLE = 4'hF;
      AVS_WRITEDATA  = 32'h0;
      repeat (12) @(posedge CLK);
      RST_B <= 1'b1;
      @(posedge CLK);
      t_reset();
      t_hw();
      t_level();
      t_edge();
      t_sync();
      t_retrig();
      t_gsel();
      t_up(32'h1D, 32'h9998);
      t_up(32'h0D, 32'hFFFE);
      conclude();
   end

   // About 12500 cycles, far beyond the scenarios
   initial begin
      #50000;
      err_count++;
      conclude();
   end
endmodule
